// ### core/lac_defines.svh
/*
 * Register offsets, field positions, reset values and counts of the lock
 * alarm and output control block.
 * Assumes inclusion by bare name from core/ files; definitions only.
 */
`ifndef LAC_DEFINES_SVH
`define LAC_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define LAC_OFF_CTRL     8'h00
`define LAC_OFF_STATUS   8'h04
`define LAC_OFF_STICKY   8'h08
`define LAC_OFF_MASK     8'h0c
`define LAC_OFF_LOL_SET  8'h10
`define LAC_OFF_LOL_CLR  8'h14
`define LAC_OFF_LOL_DLY  8'h18
`define LAC_OFF_OUT_CFG  8'h1c
`define LAC_OFF_SKEW01   8'h20
`define LAC_OFF_SKEW23   8'h24

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define LAC_CTRL_HRST    0
`define LAC_CTRL_SYNC    1
`define LAC_CTRL_BURN    2
`define LAC_CTRL_SPI3    3
`define LAC_SRC_LOS      0
`define LAC_SRC_OOF      1
`define LAC_SRC_LOL      2
`define LAC_SRC_HOLD     3
`define LAC_STAT_BURNS   4
`define LAC_STAT_SERSEL  6
`define LAC_STAT_LOADING 7
`define LAC_OC_ROUTE     0
`define LAC_OC_POLP      2
`define LAC_OC_POLN      3
`define LAC_OC_DIS       4
`define LAC_OC_DSTATE    5
`define LAC_OC_SYNC      7

// ------------------------------------------------------------
// reset values and limits (thresholds in 0.1 ppm units)
// ------------------------------------------------------------
`define LAC_RST_LOL_SET  18'h00014
`define LAC_RST_LOL_CLR  18'h00002
`define LAC_THR_MIN      18'h00002
`define LAC_THR_MAX      18'h30d40
`define LAC_RST_LOL_DLY  16'h0000
`define LAC_RST_OUT_CFG  32'h03020100
`define LAC_RST_SKEW     32'h00000000
`define LAC_RST_MASK     4'h0
`define LAC_NVM_LAST     3'h5
`define LAC_NVM_MAX_BURN 2'h2

`endif

// ### core/lac_drv_if.sv
/*
 * Carrier from the control core to one output driver.
 * Assumes one instance per driver, driven by plain assigns in lac_top; the core modport is unused.
 */
`timescale 1ns/1ns
`default_nettype none

interface lac_drv_if;
    logic             src;
    logic             gate;
    logic             dis;
    logic             pol_p;
    logic             pol_n;
    logic             sync_dis;
    lac_pkg::lac_dis_e dstate;

    modport core (output src, gate, dis, pol_p, pol_n, sync_dis, dstate);
    modport drv  (input  src, gate, dis, pol_p, pol_n, sync_dis, dstate);
endinterface

`default_nettype wire

// ### core/lac_out_gate.sv
/*
 * One output driver: enable gating, polarity, disabled level and
 * synchronous disable of the routed divider clock.
 * Assumes src is a level synchronous to pclk.
 */
`timescale 1ns/1ns
`default_nettype none

module lac_out_gate (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    lac_drv_if.drv    drv,
    output logic      out_p,
    output logic      out_n,
    output logic      out_oe
);
    logic active_r, active_nxt;
    logic p_nxt, n_nxt, oe_nxt, en, lvl;

    // ------------------------------------------------------------
    // enable decision and pin levels
    // ------------------------------------------------------------
    always_comb begin
        en  = !drv.gate && !drv.dis;                  // [RULE_12] [RULE_13]
        lvl = (drv.dstate == lac_pkg::LAC_DIS_HIGH);
        if (en) begin
            active_nxt = 1'b1;
        end else if (!drv.sync_dis || !drv.src) begin
            active_nxt = 1'b0;                        // [RULE_15]
        end else begin
            active_nxt = active_r;                    // finish the high half
        end
        p_nxt  = active_nxt ? (drv.src ^ drv.pol_p) : lvl;   // [RULE_11] [RULE_14]
        n_nxt  = active_nxt ? (drv.src ^ drv.pol_n) : lvl;
        oe_nxt = active_nxt || (drv.dstate != lac_pkg::LAC_DIS_HIZ);
    end

    // state and pin registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_r <= 1'b0;
            out_p    <= 1'b0;
            out_n    <= 1'b0;
            out_oe   <= 1'b1;
        end else if (ce) begin
            active_r <= active_nxt;
            out_p    <= p_nxt;
            out_n    <= n_nxt;
            out_oe   <= oe_nxt;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_gate_immediate: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_15]
        ce && !en && !drv.sync_dis |=> !active_r)
        else $error("driver not disabled at once");
    a_sync_wait: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_15]
        ce && active_r && drv.sync_dis && drv.src |=> active_r)
        else $error("driver cut inside a high half period");
    a_hiz_release: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_14]
        ce && !en && !drv.sync_dis && drv.dstate == lac_pkg::LAC_DIS_HIZ |=> !out_oe)
        else $error("disabled driver still drives in hiz state");
endmodule

`default_nettype wire

// ### core/lac_pkg.sv
/*
 * Types shared by the lock alarm and output control modules.
 * Assumes nothing of its surroundings.
 */
package lac_pkg;

    // ------------------------------------------------------------
    // control sequence and driver disabled state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LAC_ST_LOAD = 2'b00,
        LAC_ST_RUN  = 2'b01
    } lac_state_e;

    typedef enum logic [1:0] {
        LAC_DIS_LOW  = 2'b00,
        LAC_DIS_HIGH = 2'b01,
        LAC_DIS_HIZ  = 2'b10
    } lac_dis_e;

    typedef logic [17:0] lac_thr_t;

endpackage

// ### core/lac_top.sv
/*
 * Lock loss monitor, alarm pin with masks, output gating, crosspoint,
 * skew settings, divider realignment and power-up load from NVM,
 * all behind an APB slave.
 * Assumes all inputs synchronous to pclk and NVM read data valid in the
 * same cycle as nvm_addr.
 */
`timescale 1ns/1ns
`default_nettype none
`include "lac_defines.svh"

// Behaviour
// RULE_01 - lock loss flag set on lost sync
// RULE_02 - lock loss pin shows live state
// RULE_03 - separate set and clear frequency comparators
// RULE_04 - thresholds programmable 0.2 to 20000 ppm
// RULE_05 - optional timer delays lock loss clear
// RULE_06 - live and sticky lock loss flags
// RULE_07 - alarm on any status source event
// RULE_08 - per source mask blocks alarm
// RULE_09 - alarm drops when host clears sticky
// RULE_10 - crosspoint routes drivers, NVM default
// RULE_11 - per pin polarity, in phase default
// RULE_12 - gate pin high disables all drivers
// RULE_13 - per driver register disable bit
// RULE_14 - disabled driver low, high or hiz
// RULE_15 - optional synchronous disable avoids runt pulses
// RULE_16 - signed skew per divider path
// RULE_17 - skew defaults restored on reset, NVM
// RULE_18 - dividers reset on init and reset
// RULE_19 - sync bit realigns dividers only
// RULE_20 - NVM load at power-up, two burns
// RULE_21 - serial select pin, 3 or 4 wire
// RULE_22 - los and oof live and sticky flags
// RULE_23 - set crossing abandons clear timer
module lac_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [17:0] freq_diff,
    input  wire logic        signal_loss,
    input  wire logic        frequency_excursion,
    input  wire logic        holdover,
    input  wire logic [3:0]  synth_dividers,
    input  wire logic        out_gate,
    input  wire logic        serial_sel,
    output logic      [2:0]  nvm_addr,
    input  wire logic [31:0] nvm_rdata,
    input  wire logic        nvm_present,
    input  wire logic [1:0]  nvm_burns_used,
    output logic             nvm_burn,
    output logic             lock_loss_pin,
    output logic             alarm_pin,
    output logic      [63:0] skew_delay_paths,
    output logic             div_reset,
    output logic             div_sync,
    output logic             spi_3wire,
    output logic      [3:0]  out_p,
    output logic      [3:0]  out_n,
    output logic      [3:0]  out_oe
);
    localparam int NUM_OUT = 4;

    lac_pkg::lac_state_e st_r, st_nxt;
    logic [2:0]        idx_r, idx_nxt;
    logic [3:0]        mask_r, mask_nxt;
    lac_pkg::lac_thr_t set_thr_r, set_thr_nxt, clr_thr_r, clr_thr_nxt;
    logic [15:0]       dly_r, dly_nxt, tmr_r, tmr_nxt;
    logic [31:0]       out_cfg_r, out_cfg_nxt, skew01_r, skew01_nxt, skew23_r, skew23_nxt;
    logic              spi3_r, spi3_nxt, div_reset_r, div_reset_nxt;
    logic              div_sync_r, div_sync_nxt, burn_r, burn_nxt;
    logic              lol_r, lol_nxt, alarm_r, alarm_nxt;
    logic [3:0]        sticky_r, sticky_nxt, live;
    logic [31:0]       prdata_r, prdata_nxt;
    logic              wr_en, hrst;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic lac_pkg::lac_thr_t clamp_thr(input logic [17:0] v);
        if (v < `LAC_THR_MIN) begin
            clamp_thr = `LAC_THR_MIN;
        end else if (v > `LAC_THR_MAX) begin
            clamp_thr = `LAC_THR_MAX;
        end else begin
            clamp_thr = v;
        end
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'h0) && (a <= `LAC_OFF_SKEW23);
    endfunction

    // ------------------------------------------------------------
    // apb slave: zero wait, error on unmapped word
    // ------------------------------------------------------------
    assign pready  = ce;
    assign pslverr = psel && penable && !addr_ok(paddr);
    assign wr_en   = psel && penable && pwrite && ce && addr_ok(paddr);
    assign hrst    = wr_en && (paddr == `LAC_OFF_CTRL) && pwdata[`LAC_CTRL_HRST];
    assign prdata  = prdata_r;

    // status sources: live view
    assign live = {holdover, lol_r, frequency_excursion, signal_loss}; // [RULE_22]

    // ------------------------------------------------------------
    // configuration, load sequence and command pulses
    // ------------------------------------------------------------
    always_comb begin
        st_nxt       = st_r;
        idx_nxt      = idx_r;
        mask_nxt     = mask_r;
        set_thr_nxt  = set_thr_r;
        clr_thr_nxt  = clr_thr_r;
        dly_nxt      = dly_r;
        out_cfg_nxt  = out_cfg_r;
        skew01_nxt   = skew01_r;
        skew23_nxt   = skew23_r;
        spi3_nxt     = spi3_r;
        div_sync_nxt = 1'b0;
        burn_nxt     = 1'b0;
        if (wr_en) begin
            case (paddr)
                `LAC_OFF_CTRL: begin
                    spi3_nxt     = pwdata[`LAC_CTRL_SPI3];                  // [RULE_21]
                    div_sync_nxt = pwdata[`LAC_CTRL_SYNC];                  // [RULE_19]
                    burn_nxt     = pwdata[`LAC_CTRL_BURN]
                                   && (nvm_burns_used < `LAC_NVM_MAX_BURN); // [RULE_20]
                end
                `LAC_OFF_MASK:    mask_nxt    = pwdata[3:0];
                `LAC_OFF_LOL_SET: set_thr_nxt = clamp_thr(pwdata[17:0]);    // [RULE_04]
                `LAC_OFF_LOL_CLR: clr_thr_nxt = clamp_thr(pwdata[17:0]);    // [RULE_04]
                `LAC_OFF_LOL_DLY: dly_nxt     = pwdata[15:0];
                `LAC_OFF_OUT_CFG: out_cfg_nxt = pwdata;
                `LAC_OFF_SKEW01:  skew01_nxt  = pwdata;                     // [RULE_16]
                `LAC_OFF_SKEW23:  skew23_nxt  = pwdata;
                default: ;
            endcase
        end
        unique case (st_r)
            lac_pkg::LAC_ST_LOAD: begin
                // copy stored defaults word by word
                if (nvm_present) begin                                       // [RULE_20]
                    case (idx_r)
                        3'h0:    out_cfg_nxt = nvm_rdata;                    // [RULE_10]
                        3'h1:    set_thr_nxt = clamp_thr(nvm_rdata[17:0]);
                        3'h2:    clr_thr_nxt = clamp_thr(nvm_rdata[17:0]);
                        3'h3:    dly_nxt     = nvm_rdata[15:0];
                        3'h4:    skew01_nxt  = nvm_rdata;                    // [RULE_17]
                        default: skew23_nxt  = nvm_rdata;
                    endcase
                end
                if (idx_r == `LAC_NVM_LAST) begin
                    st_nxt = lac_pkg::LAC_ST_RUN;
                end else begin
                    idx_nxt = idx_r + 3'h1;
                end
            end
            lac_pkg::LAC_ST_RUN: ;
            default: st_nxt = lac_pkg::LAC_ST_LOAD;
        endcase
        // hard reset: back to defaults, then reload
        if (hrst) begin                                                       // [RULE_17]
            st_nxt      = lac_pkg::LAC_ST_LOAD;
            idx_nxt     = 3'h0;
            mask_nxt    = `LAC_RST_MASK;
            set_thr_nxt = `LAC_RST_LOL_SET;
            clr_thr_nxt = `LAC_RST_LOL_CLR;
            dly_nxt     = `LAC_RST_LOL_DLY;
            out_cfg_nxt = `LAC_RST_OUT_CFG;
            skew01_nxt  = `LAC_RST_SKEW;
            skew23_nxt  = `LAC_RST_SKEW;
            spi3_nxt    = 1'b0;
            div_sync_nxt = 1'b0;
            burn_nxt    = 1'b0;
        end
        div_reset_nxt = (st_nxt == lac_pkg::LAC_ST_LOAD);                     // [RULE_18]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r        <= lac_pkg::LAC_ST_LOAD;
            idx_r       <= 3'h0;
            mask_r      <= `LAC_RST_MASK;
            set_thr_r   <= `LAC_RST_LOL_SET;
            clr_thr_r   <= `LAC_RST_LOL_CLR;
            dly_r       <= `LAC_RST_LOL_DLY;
            out_cfg_r   <= `LAC_RST_OUT_CFG;
            skew01_r    <= `LAC_RST_SKEW;
            skew23_r    <= `LAC_RST_SKEW;
            spi3_r      <= 1'b0;
            div_reset_r <= 1'b1;
            div_sync_r  <= 1'b0;
            burn_r      <= 1'b0;
        end else if (ce) begin
            st_r        <= st_nxt;
            idx_r       <= idx_nxt;
            mask_r      <= mask_nxt;
            set_thr_r   <= set_thr_nxt;
            clr_thr_r   <= clr_thr_nxt;
            dly_r       <= dly_nxt;
            out_cfg_r   <= out_cfg_nxt;
            skew01_r    <= skew01_nxt;
            skew23_r    <= skew23_nxt;
            spi3_r      <= spi3_nxt;
            div_reset_r <= div_reset_nxt;
            div_sync_r  <= div_sync_nxt;
            burn_r      <= burn_nxt;
        end
    end

    // ------------------------------------------------------------
    // lock loss monitor, sticky flags and alarm
    // ------------------------------------------------------------
    always_comb begin
        lol_nxt = lol_r;
        tmr_nxt = tmr_r;
        if (st_r != lac_pkg::LAC_ST_RUN || hrst) begin
            lol_nxt = 1'b1;
            tmr_nxt = 16'h0000;
        end else if (freq_diff > set_thr_r) begin
            lol_nxt = 1'b1;                         // [RULE_01] [RULE_03]
            tmr_nxt = 16'h0000;                     // [RULE_23]
        end else if (lol_r && freq_diff < clr_thr_r) begin
            if (tmr_r >= dly_r) begin               // [RULE_05]
                lol_nxt = 1'b0;
                tmr_nxt = 16'h0000;
            end else begin
                tmr_nxt = tmr_r + 16'h0001;
            end
        end else begin
            tmr_nxt = 16'h0000;                     // inside the hysteresis band
        end
        sticky_nxt = hrst ? 4'h0 : sticky_r;
        if (wr_en && paddr == `LAC_OFF_STICKY) begin
            sticky_nxt = sticky_r & ~pwdata[3:0];   // [RULE_09]
        end
        sticky_nxt = sticky_nxt | live;             // set wins [RULE_06] [RULE_22]
        alarm_nxt  = |(sticky_r & ~mask_r);         // [RULE_07] [RULE_08]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lol_r    <= 1'b1;
            tmr_r    <= 16'h0000;
            sticky_r <= 4'h0;
            alarm_r  <= 1'b0;
        end else if (ce) begin
            lol_r    <= lol_nxt;
            tmr_r    <= tmr_nxt;
            sticky_r <= sticky_nxt;
            alarm_r  <= alarm_nxt;
        end
    end

    // ------------------------------------------------------------
    // read data, captured in the setup cycle
    // ------------------------------------------------------------
    always_comb begin
        prdata_nxt = prdata_r;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `LAC_OFF_CTRL:    prdata_nxt = {28'h0, spi3_r, 3'h0};
                `LAC_OFF_STATUS:  prdata_nxt = {24'h0, (st_r == lac_pkg::LAC_ST_LOAD),
                                                serial_sel, nvm_burns_used, live};
                `LAC_OFF_STICKY:  prdata_nxt = {28'h0, sticky_r};
                `LAC_OFF_MASK:    prdata_nxt = {28'h0, mask_r};
                `LAC_OFF_LOL_SET: prdata_nxt = {14'h0, set_thr_r};
                `LAC_OFF_LOL_CLR: prdata_nxt = {14'h0, clr_thr_r};
                `LAC_OFF_LOL_DLY: prdata_nxt = {16'h0, dly_r};
                `LAC_OFF_OUT_CFG: prdata_nxt = out_cfg_r;
                `LAC_OFF_SKEW01:  prdata_nxt = skew01_r;
                `LAC_OFF_SKEW23:  prdata_nxt = skew23_r;
                default:          prdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
        end else if (ce) begin
            prdata_r <= prdata_nxt;
        end
    end

    // outputs from registers
    assign lock_loss_pin    = lol_r;                // [RULE_02]
    assign alarm_pin        = alarm_r;
    assign skew_delay_paths = {skew23_r, skew01_r}; // [RULE_16]
    assign div_reset        = div_reset_r;
    assign div_sync         = div_sync_r;
    assign nvm_burn         = burn_r;
    assign nvm_addr         = idx_r;
    assign spi_3wire        = spi3_r;

    // ------------------------------------------------------------
    // crosspoint and drivers
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_OUT; g++) begin : g_drv
        lac_drv_if drv_if ();
        logic [7:0] c;
        assign c                = out_cfg_r[8*g +: 8];
        assign drv_if.src       = synth_dividers[c[`LAC_OC_ROUTE +: 2]]; // [RULE_10]
        assign drv_if.gate      = out_gate;                              // [RULE_12]
        assign drv_if.dis       = c[`LAC_OC_DIS];                        // [RULE_13]
        assign drv_if.pol_p     = c[`LAC_OC_POLP];                       // [RULE_11]
        assign drv_if.pol_n     = c[`LAC_OC_POLN];
        assign drv_if.sync_dis  = c[`LAC_OC_SYNC];
        assign drv_if.dstate    = lac_pkg::lac_dis_e'(c[`LAC_OC_DSTATE +: 2]);
        lac_out_gate i_lac_out_gate (
            .pclk    (pclk),
            .presetn (presetn),
            .ce      (ce),
            .drv     (drv_if.drv),
            .out_p   (out_p[g]),
            .out_n   (out_n[g]),
            .out_oe  (out_oe[g])
        );
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_lol_set: assert property ( // [RULE_03]
        ce && st_r == lac_pkg::LAC_ST_RUN && !hrst && freq_diff > set_thr_r |=> lock_loss_pin)
        else $error("lock loss not raised above set threshold");
    a_lol_delay: assert property ( // [RULE_05]
        ce && lol_r && tmr_r < dly_r && st_r == lac_pkg::LAC_ST_RUN |=> lol_r)
        else $error("lock loss cleared before delay ran out");
    a_timer_abandon: assert property ( // [RULE_23]
        ce && tmr_r != 16'h0000 && freq_diff > set_thr_r |=> tmr_r == 16'h0000 && lol_r)
        else $error("clear timer kept running after set crossing");
    a_sticky_hold: assert property ( // [RULE_06]
        ce && sticky_r[`LAC_SRC_LOL] && !(wr_en && paddr == `LAC_OFF_STICKY) && !hrst
        |=> sticky_r[`LAC_SRC_LOL])
        else $error("sticky lock loss dropped without clear");
    a_sticky_set_wins: assert property ( // [RULE_22]
        ce && signal_loss |=> sticky_r[`LAC_SRC_LOS])
        else $error("signal loss event lost");
    a_alarm_raise: assert property ( // [RULE_07]
        ce && |(sticky_r & ~mask_r) |=> alarm_pin)
        else $error("alarm pin not raised for unmasked event");
    a_alarm_masked: assert property ( // [RULE_08]
        ce && (sticky_r & ~mask_r) == 4'h0 |=> !alarm_pin)
        else $error("alarm pin raised with all sources masked or clear");
    a_burn_limit: assert property ( // [RULE_20]
        nvm_burn |-> $past(nvm_burns_used) < `LAC_NVM_MAX_BURN)
        else $error("third nvm burn issued");
    a_div_reset_load: assert property ( // [RULE_18]
        ce && hrst |=> div_reset [*6])
        else $error("dividers not held in reset across reload");

    c_lol_clears: cover property (lol_r ##1 !lol_r);
    c_alarm_clear: cover property (alarm_pin ##[1:20] !alarm_pin);
    c_burn: cover property (nvm_burn);
    c_hard_reset: cover property (hrst ##[1:10] st_r == lac_pkg::LAC_ST_RUN);
endmodule

`default_nettype wire

// ### tb/lac_nvm_model.sv
/* nvm image model answering the power-up load.
   assumes nvm_addr from lac_top, data valid the same cycle */
`timescale 1ns/1ns
`default_nettype none
module lac_nvm_model (
    input  wire logic [2:0]  addr,
    output logic      [31:0] rdata
);
    // stored image: reversed routing, 10/1 ppm, delay 3, skew0 -2, skew1 2, skew2 -1, skew3 1
    always_comb begin
        case (addr)
            3'h0:    rdata = 32'h00010203;
            3'h1:    rdata = 32'h00000064;
            3'h2:    rdata = 32'h0000000a;
            3'h3:    rdata = 32'h00000003;
            3'h4:    rdata = 32'h0002fffe;
            3'h5:    rdata = 32'h0001ffff;
            default: rdata = ~{29'h0, addr}; // unused words change with address
        endcase
    end
endmodule
`default_nettype wire

// ### tb/lac_top_test.sv
/* sequenced tests of lac_top over apb.
   assumes lac_top and lac_nvm_model compiled first */
`timescale 1ns/1ns
`default_nettype none
module lac_top_test;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, e;
    logic        signal_loss, frequency_excursion, holdover, out_gate, serial_sel;
    logic        nvm_present, nvm_burn, lock_loss_pin, alarm_pin, div_reset, div_sync;
    logic        spi_3wire;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, nvm_rdata, q;
    logic [17:0] freq_diff;
    logic [3:0]  synth_dividers, out_p, out_n, out_oe, prv, rev;
    logic [2:0]  nvm_addr;
    logic [1:0]  nvm_burns_used;
    logic [63:0] skew_delay_paths;
    int          errors, n_checks;

    lac_top i_lac_top (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .freq_diff, .signal_loss, .frequency_excursion,
        .holdover, .synth_dividers, .out_gate, .serial_sel, .nvm_addr, .nvm_rdata,
        .nvm_present, .nvm_burns_used, .nvm_burn, .lock_loss_pin, .alarm_pin,
        .skew_delay_paths, .div_reset, .div_sync, .spi_3wire, .out_p, .out_n, .out_oe);
    lac_nvm_model i_lac_nvm_model (.addr(nvm_addr), .rdata(nvm_rdata));

    // clock and free-running divider levels
    always #20 pclk = ~pclk;
    always @(posedge pclk) synth_dividers <= presetn ? synth_dividers + 4'h1 : 4'h0;

    task chk(input logic [63:0] s, input logic [63:0] x);
        n_checks++;
        if (s !== x) begin
            errors++;
            $display("unexpected t=%0t seen %h exp %h", $time, s, x);
        end
    endtask

    // one apb transfer, held until pready at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // watchdog
    initial begin
        #200000;
        errors++;
        end_sim;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {pclk, presetn, psel, penable, pwrite, signal_loss, holdover, out_gate} = '0;
        {frequency_excursion, serial_sel, paddr, pwdata, freq_diff} = '0;
        {errors, n_checks, nvm_burns_used} = '0;
        ce = 1'b1; nvm_present = 1'b1;
        repeat (5) @(posedge pclk);
        chk({div_reset, lock_loss_pin}, 2'h3);
        presetn <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            apb(1'b0, 8'h04, 32'h0);
            if (q[7] === 1'b0) break;
        end
        apb(1'b0, 8'h1c, 32'h0);
        chk(q, 32'h00010203);
        chk(skew_delay_paths, 64'h0001ffff0002fffe);
        chk(div_reset, 1'b0);
        cyc(8);
        chk(lock_loss_pin, 1'b0);
        apb(1'b0, 8'h08, 32'h0);
        chk(q[2], 1'b1);
        chk(alarm_pin, 1'b1);
        apb(1'b1, 8'h08, 32'hf);
        cyc(3);
        chk(alarm_pin, 1'b0);
        $display("test setup done");
        @(posedge pclk) freq_diff <= 18'h65;
        cyc(3);
        chk(lock_loss_pin, 1'b1);
        @(posedge pclk) freq_diff <= 18'h20;
        cyc(10);
        chk(lock_loss_pin, 1'b1);
        @(posedge pclk) freq_diff <= 18'h0;
        cyc(2);
        chk(lock_loss_pin, 1'b1);
        @(posedge pclk) freq_diff <= 18'h65;
        @(posedge pclk) freq_diff <= 18'h0;
        cyc(2);
        chk(lock_loss_pin, 1'b1);
        cyc(4);
        chk(lock_loss_pin, 1'b0);
        apb(1'b1, 8'h08, 32'hf);
        @(posedge pclk) ce <= 1'b0;
        freq_diff <= 18'h65;
        cyc(3);
        chk(lock_loss_pin, 1'b0); // state frozen while ce is low
        @(posedge pclk) ce <= 1'b1;
        freq_diff <= 18'h0;
        $display("test lock loss done");
        apb(1'b1, 8'h0c, 32'h1);
        @(posedge pclk) signal_loss <= 1'b1;
        @(posedge pclk) signal_loss <= 1'b0;
        cyc(3);
        chk(alarm_pin, 1'b0);
        apb(1'b1, 8'h0c, 32'h0);
        cyc(2);
        chk(alarm_pin, 1'b1);
        apb(1'b1, 8'h08, 32'h1);
        cyc(3);
        chk(alarm_pin, 1'b0);
        $display("test alarm done");
        prv = synth_dividers - 4'h1;
        rev = {prv[0], prv[1], prv[2], prv[3]};
        chk({out_n, out_p}, {rev, rev});
        @(posedge pclk) out_gate <= 1'b1;
        cyc(3);
        chk({out_oe, out_p}, 8'hf0);
        @(posedge pclk) out_gate <= 1'b0;
        apb(1'b0, 8'h28, 32'h0);
        chk({e, q}, 33'h100000000); // unmapped read refused
        apb(1'b1, 8'h1c, 32'h9031520b);
        cyc(3);
        prv = synth_dividers - 4'h1;
        chk({out_oe, out_n, out_p}, {4'hd, 3'h2, !prv[3], 3'h2, prv[3]});
        apb(1'b1, 8'h00, 32'he);
        cyc(0);
        chk({div_sync, nvm_burn, spi_3wire}, 3'h7);
        cyc(1);
        chk({div_sync, nvm_burn, spi_3wire}, 3'h1);
        $display("test gate done");
        end_sim;
    end
endmodule
`default_nettype wire
